// [design/halt_osc_map.vh]
// register map, field positions, reset values and wait counts for the standby block
`ifndef HALT_OSC_MAP_VH
`define HALT_OSC_MAP_VH

`define ADDR_W            20
`define OSC_CFG_ADDR      20'h0ffcf
`define STBY_CTL_ADDR     20'h0ffc0

`define OSC_CFG_RESET     8'h00
`define STBY_CTL_RESET    8'h30

`define EXT_CLK_BIT       7
`define SETTLE_SEL_HI     2
`define SETTLE_SEL_LO     0
`define OSC_CFG_RD_MASK   8'h87

`define HALT_REQ_BIT      0

`define SETTLE_MAX_EXP    5'd20
`define EXT_WAIT_CYC      21'd512
`define SETTLE_CNT_W      21

`endif

// [design/settle_timer.v]
// down counter that times the oscillator settle wait
`timescale 1ns/1ns
`default_nettype none

module settle_timer #(
    parameter W = 21
) (
    input  wire         clock_i,
    input  wire         rst_n_i,
    input  wire         start_i,
    input  wire [W-1:0] load_i,
    output wire         busy_o,
    output reg          done_o
);

    reg [W-1:0] cnt_r;

    assign busy_o = (cnt_r != {W{1'b0}});

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_r  <= {W{1'b0}};
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
            if (start_i)
                cnt_r <= load_i;
            else if (busy_o)
                cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
    end

endmodule

`default_nettype wire

// [design/halt_standby_oscillator_ctl.v]
// standby control: oscillator settle configuration and halt mode sequencing
//
// What the document requires of this block and of its software
// [R1] select bit 0 runs resonator, 1 takes external clock and stops the amplifier
// [R2] software sets external clock select before stop when an external clock feeds
// [R3] 3-bit field picks 2^20..2^13 cycle wait; external clock fixes 512 cycles
// [R4] software should pick at least 40 ms crystal, 4 ms ceramic settle wait
// [R5] settle config register changes only on full 8-bit transfer writes
// [R6] reset clears settle config to zero: resonator, longest wait
// [R7] writing the halt request bit as 1 enters halt
// [R8] standby control accepts only protected 8-bit instruction writes
// [R9] software places three no-ops after the halt request instruction
// [R10] release already active at request: skip halt, resume or take vector
// [R11] in halt clocks run, cpu stops, macro service transfers still run
// [R12] halt: low bus floats, upper lines hold, strobes high, latch strobe low
// [R13] halted: general I/O, peripherals and RAM keep their state
// [R14] halt exits only on pin nmi, unmasked maskable request, or reset
// [R15] watchdog nmi never releases halt
// [R16] pin nmi always releases; acknowledged unless blocked, else resume pending; code drops an nmi edge that comes during a macro service transfer
// [R17] unmasked request with enable set acknowledged under priority conditions
// [R18] same or higher priority handler active: resume and hold request pending; code acks level 3 under level 3 handler when priority_mode_select_i is 0
// [R19] macro service: one transfer then halt again unless end without end-irq
// [R20] pending request acknowledged as soon as conditions allow
// [R21] released nmi branches if acknowledgeable, else next instruction runs
// [R22] unmasked request with enable clear releases halt without taking interrupt
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "halt_osc_map.vh"

module halt_standby_oscillator_ctl #(
    parameter [4:0]  SETTLE_MAX_EXP = `SETTLE_MAX_EXP,
    parameter [20:0] EXT_WAIT_CYC   = `EXT_WAIT_CYC
) (
    input  wire                 clock_i,
    input  wire                 rst_n_i,
    // register port
    input  wire [`ADDR_W-1:0]   addr_i,
    input  wire [7:0]           wdata_i,
    input  wire                 wr_i,
    input  wire                 rd_i,
    input  wire                 wr_full_byte_i,
    input  wire                 wr_protected_i,
    output reg  [7:0]           rdata_o,
    // oscillator
    output wire                 osc_amp_en_o,
    output wire                 external_clock_select_o,
    input  wire                 stop_release_i,
    output wire                 settle_busy_o,
    output wire                 settle_done_o,
    // release sources
    input  wire                 nmi_pin_i,
    input  wire                 wdt_nmi_i,
    input  wire                 nmi_blocked_i,
    input  wire                 irq_req_i,
    input  wire                 source_mask_bit_i,
    input  wire [1:0]           irq_prio_i,
    input  wire                 global_irq_enable_i,
    input  wire                 isr_active_i,
    input  wire [1:0]           isr_prio_i,
    input  wire                 priority_mode_select_i,
    input  wire                 ms_req_i,
    input  wire                 ms_mask_i,
    input  wire                 ms_done_i,
    input  wire                 ms_end_i,
    input  wire                 irq_on_end_bit_i,
    // cpu side
    output wire                 cpu_run_o,
    output wire                 halted_o,
    output wire                 ms_grant_o,
    output reg                  nmi_ack_o,
    output reg                  irq_ack_o,
    output reg                  resume_next_o,
    output reg                  nmi_pending_o,
    output reg                  irq_pending_o,
    // bus pins
    input  wire [7:0]           ad_low_out_i,
    input  wire                 ad_low_drive_i,
    input  wire [11:0]          upper_addr_i,
    input  wire                 rd_n_i,
    input  wire                 wr_n_i,
    input  wire                 addr_latch_i,
    output wire [7:0]           muxed_addr_data_low_o,
    output wire                 muxed_addr_data_low_oe_n_o,
    output reg  [11:0]          upper_address_lines_o,
    output wire                 rd_n_o,
    output wire                 wr_n_o,
    output wire                 address_latch_strobe_o
);

    localparam [1:0] ST_RUN  = 2'd0;
    localparam [1:0] ST_HALT = 2'd1;
    localparam [1:0] ST_MSVC = 2'd2;

    reg  [7:0]  osc_cfg_r;
    reg  [7:0]  stby_ctl_r;
    reg  [1:0]  st_r;
    reg  [1:0]  st_nxt;
    reg         ms_grant_r;
    reg         nmi_s1_r;
    reg         nmi_s2_r;
    reg         nmi_s3_r;
    reg         nmi_lvl_r;
    reg         nmi_evt_r;

    wire        hit_osc   = (addr_i == `OSC_CFG_ADDR);
    wire        hit_stby  = (addr_i == `STBY_CTL_ADDR);
    wire        osc_wr    = wr_i & hit_osc & wr_full_byte_i;         // [R5]
    wire        stby_wr   = wr_i & hit_stby & wr_protected_i;        // [R8]
    wire        halt_req  = stby_wr & wdata_i[`HALT_REQ_BIT] & (st_r == ST_RUN); // [R7]
    wire        ext_clk   = osc_cfg_r[`EXT_CLK_BIT];
    wire [2:0]  sel_code  = osc_cfg_r[`SETTLE_SEL_HI:`SETTLE_SEL_LO];

    // settle wait length
    wire [4:0]  settle_shift = SETTLE_MAX_EXP - {2'b00, sel_code};
    wire [20:0] settle_load  = ext_clk ? EXT_WAIT_CYC                 // [R3]
                                       : (21'd1 << settle_shift);    // [R3]

    settle_timer #(
        .W       (`SETTLE_CNT_W)
    ) u_settle (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .start_i (stop_release_i),
        .load_i  (settle_load),
        .busy_o  (settle_busy_o),
        .done_o  (settle_done_o)
    );

    assign external_clock_select_o = ext_clk;
    assign osc_amp_en_o            = ~ext_clk;                        // [R1]

    // acknowledge decisions
    wire irq_unmasked = irq_req_i & ~source_mask_bit_i;
    wire irq_prio_ok  = ~isr_active_i
                      | (isr_prio_i > irq_prio_i)                     // [R17]
                      | (~priority_mode_select_i & (isr_prio_i == 2'd3)
                         & (irq_prio_i == 2'd3));                     // [R17]
    wire irq_can_ack  = global_irq_enable_i & irq_prio_ok;
    wire nmi_can_ack  = ~nmi_blocked_i;                               // [R16]

    // only the pin source counts; the watchdog request is not looked at here
    wire wdt_unused   = wdt_nmi_i;                                    // [R15]
    wire halt_like    = (st_r == ST_HALT) | halt_req;
    wire ms_release   = (st_r == ST_MSVC) & ms_done_i & ms_end_i & ~irq_on_end_bit_i; // [R19]

    wire rel_nmi = ((st_r == ST_HALT) & nmi_evt_r)                    // [R14]
                 | (halt_req & nmi_lvl_r);                            // [R10]
    wire rel_irq = ~rel_nmi & ((halt_like & irq_unmasked)             // [R14]
                 | ms_release);                                       // [R19]
    // a watchdog request must not hold off macro service either
    wire ms_start = (st_r == ST_HALT) & ~rel_nmi & ~rel_irq
                  & ms_req_i & ~ms_mask_i;                            // [R19]

    wire nmi_ack_nxt = nmi_can_ack & (rel_nmi | (nmi_pending_o & (st_r == ST_RUN))); // [R20]
    wire irq_ack_nxt = ~nmi_ack_nxt & irq_can_ack
                     & (rel_irq | (irq_pending_o & (st_r == ST_RUN)));               // [R20]
    wire resume_nxt  = (rel_nmi & ~nmi_can_ack)                       // [R21]
                     | (rel_irq & ~(irq_can_ack & ~nmi_ack_nxt));     // [R22]

    always @*
    begin
        st_nxt = st_r;
        case (st_r)
            ST_RUN:
            begin
                if (halt_req & ~rel_nmi & ~rel_irq)
                    st_nxt = ST_HALT;                                 // [R7]
            end
            ST_HALT:
            begin
                if (rel_nmi | rel_irq)
                    st_nxt = ST_RUN;
                else if (ms_start)
                    st_nxt = ST_MSVC;                                 // [R11]
            end
            ST_MSVC:
            begin
                if (ms_release)
                    st_nxt = ST_RUN;
                else if (ms_done_i)
                    st_nxt = ST_HALT;                                 // [R19]
            end
            default:
                st_nxt = ST_RUN;
        endcase
    end

    // pin nmi: three stages, level moves only once stages two and three agree
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            nmi_s1_r  <= 1'b0;
            nmi_s2_r  <= 1'b0;
            nmi_s3_r  <= 1'b0;
            nmi_lvl_r <= 1'b0;
            nmi_evt_r <= 1'b0;
        end
        else
        begin
            nmi_s1_r  <= nmi_pin_i;
            nmi_s2_r  <= nmi_s1_r;
            nmi_s3_r  <= nmi_s2_r;
            if (nmi_s2_r == nmi_s3_r)
                nmi_lvl_r <= nmi_s3_r;
            nmi_evt_r <= (nmi_s2_r == nmi_s3_r) & nmi_s3_r & ~nmi_lvl_r;
        end
    end

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            osc_cfg_r     <= `OSC_CFG_RESET;                          // [R6]
            stby_ctl_r    <= `STBY_CTL_RESET;
            st_r          <= ST_RUN;
            ms_grant_r    <= 1'b0;
            nmi_ack_o     <= 1'b0;
            irq_ack_o     <= 1'b0;
            resume_next_o <= 1'b0;
            nmi_pending_o <= 1'b0;
            irq_pending_o <= 1'b0;
        end
        else
        begin
            if (osc_wr)
                osc_cfg_r <= wdata_i & `OSC_CFG_RD_MASK;              // [R5]
            if (stby_wr)
                stby_ctl_r <= wdata_i;                                // [R8]
            st_r          <= st_nxt;
            ms_grant_r    <= ms_start;
            nmi_ack_o     <= nmi_ack_nxt;
            irq_ack_o     <= irq_ack_nxt;
            resume_next_o <= resume_nxt;
            // set wins over clear: a new blocked release keeps the flag up
            nmi_pending_o <= (rel_nmi & ~nmi_can_ack)
                           | (nmi_pending_o & ~nmi_ack_nxt);          // [R16]
            irq_pending_o <= (rel_irq & global_irq_enable_i & ~irq_prio_ok)
                           | (irq_pending_o & ~irq_ack_nxt);          // [R18]
        end
    end

    // read data one cycle after the strobe; unmapped reads give zero
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_o <= 8'h00;
        else if (rd_i & hit_osc)
            rdata_o <= osc_cfg_r;
        else if (rd_i & hit_stby)
            rdata_o <= {stby_ctl_r[7:1], (st_r != ST_RUN)};
        else
            rdata_o <= 8'h00;
    end

    assign cpu_run_o  = (st_r == ST_RUN);                             // [R11]
    assign halted_o   = (st_r != ST_RUN);                             // [R13]
    assign ms_grant_o = ms_grant_r;                                   // [R11]

    // upper lines captured while running and frozen in halt
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            upper_address_lines_o <= 12'h000;
        else if (st_r != ST_HALT)
            upper_address_lines_o <= upper_addr_i;                    // [R12]
    end

    // macro service needs the bus, so pins are only parked in plain halt
    assign muxed_addr_data_low_o      = ad_low_out_i;
    assign muxed_addr_data_low_oe_n_o = (st_r == ST_HALT) | ~ad_low_drive_i; // [R12]
    assign rd_n_o                     = (st_r == ST_HALT) | rd_n_i;   // [R12]
    assign wr_n_o                     = (st_r == ST_HALT) | wr_n_i;   // [R12]
    assign address_latch_strobe_o     = (st_r != ST_HALT) & addr_latch_i; // [R12]

endmodule

`default_nettype wire

// [dv/halt_standby_oscillator_ctl_checker.sv]
// concurrent checks on the halt and oscillator control ports
`timescale 1ns/1ns
`default_nettype none
module halt_checker (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        wr_i,
    input wire logic        wr_protected_i,
    input wire logic        nmi_pin_i,
    input wire logic        irq_req_i,
    input wire logic        source_mask_bit_i,
    input wire logic        ms_done_i,
    input wire logic        osc_amp_en_o,
    input wire logic        external_clock_select_o,
    input wire logic        cpu_run_o,
    input wire logic        halted_o,
    input wire logic        ms_grant_o,
    input wire logic        nmi_ack_o,
    input wire logic        irq_ack_o,
    input wire logic        resume_next_o,
    input wire logic        muxed_addr_data_low_oe_n_o,
    input wire logic [11:0] upper_address_lines_o,
    input wire logic        rd_n_o,
    input wire logic        wr_n_o,
    input wire logic        address_latch_strobe_o
);
    logic msv_r;
    // pins are parked only outside a macro service transfer
    wire  plain = halted_o && !msv_r && !ms_grant_o;
    wire  live  = irq_req_i && !source_mask_bit_i;
    always_ff @(posedge clock_i or negedge rst_n_i)
        if (!rst_n_i)
            msv_r <= 1'b0;
        else
            msv_r <= ms_grant_o || (msv_r && !ms_done_i && halted_o);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    amp_follows_ext_a: assert property (osc_amp_en_o == !external_clock_select_o)
        else $error("amplifier enable disagrees with clock select");
    pins_parked_a: assert property (plain |-> muxed_addr_data_low_oe_n_o && rd_n_o
        && wr_n_o && !address_latch_strobe_o) else $error("bus pins not parked");
    upper_held_a: assert property (plain && $past(plain) |-> $stable(upper_address_lines_o))
        else $error("upper address moved in halt");
    halt_kept_a: assert property ((!nmi_pin_i)[*8] ##0 (plain && !live) |=> halted_o)
        else $error("halt left without a release source");
    irq_releases_a: assert property (plain && live |=> cpu_run_o
        && (irq_ack_o || resume_next_o || nmi_ack_o)) else $error("request did not release");
    entry_by_write_a: assert property (cpu_run_o ##1 halted_o |-> $past(wr_i && wr_protected_i))
        else $error("halt entered without protected write");
    no_halt_live_a: assert property (cpu_run_o && live |=> !halted_o)
        else $error("halt entered with release pending");
    nmi_alone_a: assert property (nmi_ack_o |-> !irq_ack_o && !resume_next_o)
        else $error("nmi acknowledge overlaps another outcome");
endmodule

bind halt_standby_oscillator_ctl halt_checker chk_i (.clock_i, .rst_n_i, .wr_i,
    .wr_protected_i, .nmi_pin_i, .irq_req_i, .source_mask_bit_i, .ms_done_i, .osc_amp_en_o,
    .external_clock_select_o, .cpu_run_o, .halted_o, .ms_grant_o, .nmi_ack_o, .irq_ack_o,
    .resume_next_o, .muxed_addr_data_low_oe_n_o, .upper_address_lines_o, .rd_n_o, .wr_n_o,
    .address_latch_strobe_o);
`default_nettype wire

// [dv/irq_partner.sv]
// interrupt controller stand-in: requests stay up until served
`timescale 1ns/1ns
`default_nettype none
module irq_partner (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic irq_kick_i,
    input  wire logic ms_kick_i,
    input  wire logic irq_ack_i,
    input  wire logic ms_grant_i,
    output logic      irq_req_o,
    output logic      ms_req_o,
    output logic      ms_done_o
);
    logic [2:0] lat_r;
    always_ff @(posedge clock_i or negedge rst_n_i)
        if (!rst_n_i)
        begin
            irq_req_o <= 1'b0;
            ms_req_o  <= 1'b0;
            lat_r     <= 3'h0;
        end
        else
        begin
            irq_req_o <= irq_kick_i || (irq_req_o && !irq_ack_i);
            ms_req_o  <= ms_kick_i || (ms_req_o && !ms_grant_i);
            lat_r     <= ms_grant_i ? 3'h4 : lat_r - {2'h0, lat_r != 3'h0};
        end
    assign ms_done_o = lat_r == 3'h1;
endmodule
`default_nettype wire

// [dv/test_halt_standby_oscillator_ctl.sv]
// self-checking bench for the halt and oscillator control block
`timescale 1ns/1ns
`default_nettype none
`include "halt_osc_map.vh"
module test_halt_standby_oscillator_ctl;
    logic        clock = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, full = 1'b1, prot = 1'b0;
    logic        srel = 1'b0, nmi = 1'b0, wdt = 1'b0, blk = 1'b0, msk = 1'b0, ie = 1'b0;
    logic        act = 1'b0, pm = 1'b1, mmsk = 1'b0, on_end = 1'b1, ik = 1'b0, mk = 1'b0;
    logic        mend = 1'b1;
    logic [1:0]  prio = 2'h2;
    logic [19:0] addr = 20'h0;
    logic [7:0]  wdata = 8'h0;
    logic [11:0] up = 12'h0;
    int          failures = 0, checks = 0, cyc = 0, gcnt = 0;
    wire  [7:0]  rdata;
    wire  [7:0]  adl;
    wire         sbusy;
    wire         ireq, mreq, mdone, run, halt_request_bit, grant, nack, iack, res, npend, ipend, sdone, amp;

    halt_standby_oscillator_ctl #(.SETTLE_MAX_EXP(5'd8)) dut (.clock_i(clock), .rst_n_i(rst_n),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .wr_full_byte_i(full),
        .wr_protected_i(prot), .rdata_o(rdata), .osc_amp_en_o(amp),
        .external_clock_select_o(), .stop_release_i(srel), .settle_busy_o(sbusy),
        .settle_done_o(sdone), .nmi_pin_i(nmi), .wdt_nmi_i(wdt), .nmi_blocked_i(blk),
        .irq_req_i(ireq), .source_mask_bit_i(msk), .irq_prio_i(prio),
        .global_irq_enable_i(ie), .isr_active_i(act), .isr_prio_i(prio),
        .priority_mode_select_i(pm), .ms_req_i(mreq), .ms_mask_i(mmsk), .ms_done_i(mdone),
        .ms_end_i(mend), .irq_on_end_bit_i(on_end), .cpu_run_o(run), .halted_o(halt_request_bit),
        .ms_grant_o(grant), .nmi_ack_o(nack), .irq_ack_o(iack), .resume_next_o(res),
        .nmi_pending_o(npend), .irq_pending_o(ipend), .ad_low_out_i(8'h5a),
        .ad_low_drive_i(up[3]), .upper_addr_i(up), .rd_n_i(up[0]), .wr_n_i(up[1]),
        .addr_latch_i(up[2]), .muxed_addr_data_low_o(adl), .muxed_addr_data_low_oe_n_o(),
        .upper_address_lines_o(), .rd_n_o(), .wr_n_o(), .address_latch_strobe_o());
    irq_partner far (.clock_i(clock), .rst_n_i(rst_n), .irq_kick_i(ik), .ms_kick_i(mk),
        .irq_ack_i(iack), .ms_grant_i(grant), .irq_req_o(ireq), .ms_req_o(mreq),
        .ms_done_o(mdone));

    initial forever #4 clock = ~clock;
    task chk(input logic [15:0] a, input logic [15:0] e);
        checks++;
        if (a !== e)
        begin
            failures++;
            $display("[ERR] t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    task wrt(input logic [19:0] a, input logic [7:0] d, input logic f, input logic p);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        full <= f;
        prot <= p;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task rdc(input logic [19:0] a, input logic [7:0] e);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task halt(input logic [3:0] e);
        wrt(`STBY_CTL_ADDR, 8'h31, 1'b1, 1'b1);
        #1 chk({halt_request_bit, nack, iack, res}, e);
    endtask
    task kick(input logic m);
        @(posedge clock);
        ik <= !m;
        mk <= m;
        @(posedge clock);
        ik <= 1'b0;
        mk <= 1'b0;
    endtask
    // waits for an outcome pulse in run state; expects nmi, irq, resume bits
    task rel(input logic [2:0] e);
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            #1 n++;
        end while (!(run === 1'b1 && {nack, iack, res} !== 3'h0) && n < 60);
        chk({nack, iack, res}, e);
    endtask
    task settle(input int w);
        int n;
        n = 0;
        @(posedge clock);
        srel <= 1'b1;
        @(posedge clock);
        srel <= 1'b0;
        #1 chk(sbusy, 1'b1);
        while (sdone !== 1'b1 && n < 700)
        begin
            @(posedge clock);
            #1 n++;
        end
        chk(16'(n), 16'(w));
    endtask
    task give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clock)
    begin
        up <= up + 12'h1;
        cyc++;
        if (grant === 1'b1)
            gcnt++;
        if (cyc == 6000)
        begin
            failures++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        rdc(`OSC_CFG_ADDR, 8'h00);
        rdc(`STBY_CTL_ADDR, 8'h30);
        wrt(`OSC_CFG_ADDR, 8'hff, 1'b1, 1'b0);
        rdc(`OSC_CFG_ADDR, 8'h87);
        chk(amp, 1'b0);
        settle(512);
        wrt(`OSC_CFG_ADDR, 8'h05, 1'b0, 1'b0);
        rdc(`OSC_CFG_ADDR, 8'h87);
        rdc(20'h0ffce, 8'h00);
        for (int c = 0; c < 8; c++)
        begin
            wrt(`OSC_CFG_ADDR, 8'(c), 1'b1, 1'b0);
            settle(1 << (8 - c));
        end
        $display("test settle done");
        msk <= 1'b1;
        mmsk <= 1'b1;
        wdt <= 1'b1;
        wrt(`STBY_CTL_ADDR, 8'h31, 1'b1, 1'b0);
        #1 chk(halt_request_bit, 1'b0);
        kick(1'b0);
        halt(4'h8);
        repeat (20) @(posedge clock);
        #1 chk(halt_request_bit, 1'b1);
        @(posedge clock);
        msk <= 1'b0;
        wdt <= 1'b0;
        rel(3'b001);
        chk(ipend, 1'b0);
        ie <= 1'b1;
        act <= 1'b1;
        halt(4'h1);
        chk(ipend, 1'b1);
        @(posedge clock);
        act <= 1'b0;
        rel(3'b010);
        $display("test maskable done");
        act <= 1'b1;
        prio <= 2'h3;
        pm <= 1'b0;
        halt(4'h8);
        kick(1'b0);
        rel(3'b010);
        act <= 1'b0;
        mmsk <= 1'b0;
        halt(4'h8);
        kick(1'b1);
        repeat (12) @(posedge clock);
        #1 chk({gcnt[3:0], halt_request_bit, run}, 6'h6);
        on_end <= 1'b0;
        mend <= 1'b0;
        kick(1'b1);
        repeat (12) @(posedge clock);
        #1 chk({gcnt[3:0], halt_request_bit, run}, 6'ha);
        mend <= 1'b1;
        kick(1'b1);
        rel(3'b010);
        $display("test macro done");
        halt(4'h8);
        nmi <= 1'b1;
        rel(3'b100);
        nmi <= 1'b0;
        blk <= 1'b1;
        repeat (10) @(posedge clock);
        halt(4'h8);
        nmi <= 1'b1;
        rel(3'b001);
        chk(npend, 1'b1);
        @(posedge clock);
        blk <= 1'b0;
        rel(3'b100);
        halt(4'h4);
        $display("test nmi done");
        nmi <= 1'b0;
        rst_n <= 1'b0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        rdc(`OSC_CFG_ADDR, 8'h00);
        chk({amp, halt_request_bit, npend}, 3'h4);
        chk(adl, 8'h5a);
        $display("test reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
